// *** hw/supply_status_map.vh ***
/*
  Constants for the supply status reporting block: status word layout, error codes,
  link characters and log scheduler timing.
  Assumes a 50 MHz controller clock and inclusion by bare name.
*/
// Operation
// - Status pins are active low; asserted condition drives 0, idle drives 1.
// - Standby and CV pins follow device state continuously; error pin follows the registered trip latch.
// - Standby pin asserted whenever unit is in standby with output blocked.
// - Constant-voltage pin asserted while regulation runs in constant-voltage mode.
// - Error pin asserted after overvoltage trip and held until cleared.
// - Overvoltage latch clears in any standby cycle without a new trip; host commands standby.
// - Either status-read command returns the status word on the host link.
// - On network link only bits 2..0 meaningful; host ignores the rest.
// - Bits 2..0 code last command error: syntax through read failure, 1..6.
// - Bits 15..12 flag parity, overrun, framing and timeout receive errors.
// - Bit 11 echo, bit 9 RTS/CTS, bit 8 XON/XOFF flow control.
// - Bit 7 parity enable; bit 6 parity sense, 1 odd, 0 even.
// - Bit 5 stop bits, 1 means two; bit 4 length, 1 means eight.
// - Software flow control pauses with 0x13 and resumes with 0x11.
// - Port parameters change by port command, persist only after save command.
// - Commands switch unit to remote unless auto-remote disabled with argument zero.
// - Log interval programmable in whole seconds from 1 to 4294967.
// - Interval comes from first-line entry of log file, else 60 seconds.
// - Logging runs only outside standby with log file card present.
// - Each record write shows indicator filled about 1 s; card full shown.
// - Record holds tab-separated mode, limit state, voltage and current fields.
`ifndef SUPPLY_STATUS_MAP_VH
`define SUPPLY_STATUS_MAP_VH

`define CLK_HZ 32'd50000000
`define FILL_TIME_MS 32'd1000
`define FILL_CYCLES ((`CLK_HZ / 32'd1000) * `FILL_TIME_MS)
`define LOG_INTERVAL_DEFAULT_S 32'd60
`define LOG_INTERVAL_MIN_S 32'd1
`define LOG_INTERVAL_MAX_S 32'd4294967

`define ERR_NONE 3'h0
`define ERR_SYNTAX 3'h1
`define ERR_COMMAND 3'h2
`define ERR_RANGE 3'h3
`define ERR_UNIT 3'h4
`define ERR_HARDWARE 3'h5
`define ERR_READ 3'h6

`define SW_PARITY_ERR 15
`define SW_OVERRUN_ERR 14
`define SW_FRAMING_ERR 13
`define SW_TIMEOUT_ERR 12
`define SW_ECHO 11
`define SW_RTSCTS 9
`define SW_XONXOFF 8
`define SW_PAR_EN 7
`define SW_PAR_ODD 6
`define SW_STOP2 5
`define SW_LEN8 4
`define SW_RSVD_HI 10
`define SW_RSVD_LO 3

`define PORT_CFG_RESET 8'h10
`define PORT_CFG_W 8

`define CHAR_PAUSE 8'h13
`define CHAR_RESUME 8'h11
`define CHAR_TAB 8'h09
`define CHAR_LF 8'h0A

`endif

// *** hw/supply_status_reporting.v ***
/*
  Status pins, host status word, port configuration, remote switching and data-log
  scheduling for a programmable supply controller.
  Assumes the command parser delivers decoded one-cycle command strobes, the card
  layer delivers the parsed interval and accepts one tab-separated byte per handshake.
  Port parameter byte, msb first: echo, rtscts, xonxoff, parity enable, parity odd,
  two stop bits, eight data bits, spare. Field codes arrive one byte each, already
  formatted by the caller; the card layer owns file access and free-space sensing.
*/
`timescale 1ns/100ps
`include "supply_status_map.vh"

module supply_status_reporting #(
  parameter FILL_CYCLES = `FILL_CYCLES,
  parameter CLK_HZ = `CLK_HZ,
  parameter REC_FIELDS = 4
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire reset_n_in,
  // Device state
  input wire standby_in,
  input wire cv_mode_in,
  input wire ovp_trip_in,
  // Link type and receive errors
  input wire link_is_lan_in,
  input wire rx_parity_err_in,
  input wire rx_overrun_err_in,
  input wire rx_framing_err_in,
  input wire rx_timeout_err_in,
  // Decoded commands
  input wire cmd_valid_in,
  input wire [2:0] cmd_error_in,
  input wire read_status_word_cmd_in,
  input wire query_status_word_cmd_in,
  input wire set_port_params_cmd_in,
  input wire [7:0] port_params_in,
  input wire save_settings_cmd_in,
  input wire auto_remote_toggle_cmd_in,
  input wire auto_remote_arg_in,
  // Log card
  input wire card_present_in,
  input wire log_file_found_in,
  input wire card_full_in,
  input wire interval_given_in,
  input wire [31:0] interval_s_in,
  input wire [7:0] mode_code_in,
  input wire [7:0] limit_code_in,
  input wire [7:0] volt_code_in,
  input wire [7:0] curr_code_in,
  input wire log_ready_in,
  // Status pins, active low
  output wire standby_n_out,
  output wire const_voltage_flag_n_out,
  output wire ovp_error_n_out,
  // Status word answer
  output reg [15:0] link_status_word_out,
  output reg status_valid_out,
  // Serial link configuration
  output reg [7:0] port_cfg_out,
  output reg [7:0] saved_cfg_out,
  output reg save_strobe_out,
  output wire [7:0] pause_char_out,
  output wire [7:0] resume_char_out,
  output reg remote_out,
  // Log output
  output reg [7:0] log_byte_out,
  output reg log_valid_out,
  output reg log_active_out,
  output reg [31:0] log_interval_out,
  output reg log_fill_out,
  output reg log_card_full_out
);

////////////////////////////////////////////////////////////////////////////////

localparam ST_IDLE = 2'd0;
localparam ST_FIELD = 2'd1;
localparam ST_SEP = 2'd2;

reg ovp_latch_ff;
reg [2:0] err_code_ff;
reg auto_remote_ff;
reg [31:0] sec_cnt_ff;
reg [31:0] sec_tick_cnt_ff;
reg [31:0] fill_cnt_ff;
reg [1:0] state_ff;
reg [1:0] field_ff;
wire sec_tick;
wire logging;
wire status_req;
reg [15:0] word_now;
wire [31:0] interval_now;
wire fill_busy;
wire record_due;

function [31:0] clamp_interval;
  input [31:0] value;
  begin
    if (value < `LOG_INTERVAL_MIN_S)
      clamp_interval = `LOG_INTERVAL_MIN_S;
    else if (value > `LOG_INTERVAL_MAX_S)
      clamp_interval = `LOG_INTERVAL_MAX_S;
    else
      clamp_interval = value;
  end
endfunction

function [7:0] field_byte;
  input [1:0] idx;
  begin
    case (idx)
      2'd0: field_byte = mode_code_in;
      2'd1: field_byte = limit_code_in;
      2'd2: field_byte = volt_code_in;
      default: field_byte = curr_code_in;
    endcase
  end
endfunction

function last_field;
  input [1:0] idx;
  begin
    last_field = (idx == REC_FIELDS - 1);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Status pins

// Standby and CV pins are combinational so they never lag the state; the error pin follows the trip latch
assign standby_n_out = ~standby_in;
assign const_voltage_flag_n_out = ~cv_mode_in;
assign ovp_error_n_out = ~ovp_latch_ff;

always @(posedge ref_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    ovp_latch_ff <= 1'b0;
  end else if (ovp_trip_in) begin
    // Trip wins over a same-cycle standby clear
    ovp_latch_ff <= 1'b1;
  end else if (standby_in) begin
    ovp_latch_ff <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Status word

assign status_req = read_status_word_cmd_in | query_status_word_cmd_in;
// Built bit by bit; the internal bits are simply held low
always @* begin
  word_now = 16'h0000;
  if (link_is_lan_in) begin
    word_now[2:0] = err_code_ff;
  end else begin
    word_now[`SW_PARITY_ERR] = rx_parity_err_in;
    word_now[`SW_OVERRUN_ERR] = rx_overrun_err_in;
    word_now[`SW_FRAMING_ERR] = rx_framing_err_in;
    word_now[`SW_TIMEOUT_ERR] = rx_timeout_err_in;
    word_now[`SW_ECHO] = port_cfg_out[7];
    word_now[`SW_RSVD_HI] = 1'b0;
    word_now[`SW_RTSCTS] = port_cfg_out[6];
    word_now[`SW_XONXOFF] = port_cfg_out[5];
    word_now[`SW_PAR_EN] = port_cfg_out[4];
    word_now[`SW_PAR_ODD] = port_cfg_out[3];
    word_now[`SW_STOP2] = port_cfg_out[2];
    word_now[`SW_LEN8] = port_cfg_out[1];
    word_now[`SW_RSVD_LO] = 1'b0;
    word_now[2:0] = err_code_ff;
  end
end

always @(posedge ref_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    err_code_ff <= `ERR_NONE;
    link_status_word_out <= 16'h0000;
    status_valid_out <= 1'b0;
  end else begin
    status_valid_out <= status_req;
    if (status_req)
      link_status_word_out <= word_now;
    // A new error in the read cycle wins over the clear, so none is lost
    if (cmd_valid_in && cmd_error_in != `ERR_NONE)
      err_code_ff <= cmd_error_in;
    else if (status_req)
      err_code_ff <= `ERR_NONE;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Port configuration and remote

// Bit order: echo, rtscts, xonxoff, par_en, par_odd, stop2, len8, spare
assign pause_char_out = `CHAR_PAUSE;
assign resume_char_out = `CHAR_RESUME;

always @(posedge ref_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    port_cfg_out <= `PORT_CFG_RESET;
    saved_cfg_out <= `PORT_CFG_RESET;
    save_strobe_out <= 1'b0;
    auto_remote_ff <= 1'b1;
    remote_out <= 1'b0;
  end else begin
    save_strobe_out <= save_settings_cmd_in;
    if (set_port_params_cmd_in)
      port_cfg_out <= port_params_in;
    // Save copies the value held before a same-cycle set
    if (save_settings_cmd_in)
      saved_cfg_out <= port_cfg_out;
    if (auto_remote_toggle_cmd_in)
      auto_remote_ff <= auto_remote_arg_in;
    // Remote is only ever set here; going back to local is not this block's job
    if (cmd_valid_in && auto_remote_ff && !auto_remote_toggle_cmd_in)
      remote_out <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Log scheduler

assign logging = !standby_in && card_present_in && log_file_found_in;
assign sec_tick = (sec_tick_cnt_ff == CLK_HZ - 1);
// Interval is re-read every cycle; a changed file applies at the next second
assign interval_now = interval_given_in ?
  clamp_interval(interval_s_in) : `LOG_INTERVAL_DEFAULT_S;
assign fill_busy = (fill_cnt_ff != 32'h00000000);
// A full card skips the record; the second count runs on until space returns
assign record_due = sec_tick && (sec_cnt_ff + 32'h00000001 >= interval_now) &&
  !card_full_in;

always @(posedge ref_clk_in or negedge reset_n_in) begin
  if (!reset_n_in) begin
    sec_tick_cnt_ff <= 32'h00000000;
    sec_cnt_ff <= 32'h00000000;
    log_interval_out <= `LOG_INTERVAL_DEFAULT_S;
    log_active_out <= 1'b0;
    log_card_full_out <= 1'b0;
    fill_cnt_ff <= 32'h00000000;
    log_fill_out <= 1'b0;
    state_ff <= ST_IDLE;
    field_ff <= 2'd0;
    log_byte_out <= 8'h00;
    log_valid_out <= 1'b0;
  end else begin
    log_interval_out <= interval_now;
    log_active_out <= logging;
    log_card_full_out <= card_full_in;
    // Seconds count only while logging, so a new run starts a fresh interval
    if (!logging || sec_tick)
      sec_tick_cnt_ff <= 32'h00000000;
    else
      sec_tick_cnt_ff <= sec_tick_cnt_ff + 32'h00000001;
    if (fill_busy)
      fill_cnt_ff <= fill_cnt_ff - 32'h00000001;
    log_fill_out <= fill_busy;
    case (state_ff)
      ST_IDLE: begin
        log_valid_out <= 1'b0;
        if (!logging) begin
          sec_cnt_ff <= 32'h00000000;
        end else if (sec_tick) begin
          if (record_due) begin
            sec_cnt_ff <= 32'h00000000;
            field_ff <= 2'd0;
            log_byte_out <= field_byte(2'd0);
            log_valid_out <= 1'b1;
            state_ff <= ST_FIELD;
            fill_cnt_ff <= FILL_CYCLES;
          end else begin
            sec_cnt_ff <= sec_cnt_ff + 32'h00000001;
          end
        end
      end
      ST_FIELD: begin
        if (log_ready_in) begin
          // Tab between fields, line feed closes the record
          log_byte_out <= last_field(field_ff) ? `CHAR_LF : `CHAR_TAB;
          state_ff <= ST_SEP;
        end
      end
      ST_SEP: begin
        // Valid stays high across the record so the sink sees one burst
        if (log_ready_in) begin
          if (last_field(field_ff)) begin
            log_valid_out <= 1'b0;
            state_ff <= ST_IDLE;
          end else begin
            field_ff <= field_ff + 2'd1;
            log_byte_out <= field_byte(field_ff + 2'd1);
            state_ff <= ST_FIELD;
          end
        end
      end
      default: begin
        state_ff <= ST_IDLE;
        log_valid_out <= 1'b0;
      end
    endcase
  end
end

endmodule // supply_status_reporting

// *** test/host_link_model.sv ***
/* Host side of the link: turns bench opcodes into one-cycle commands and a held standby level.
   Assumes the bench changes op_in at the rising edge. */
`timescale 1ns/100ps
module host_link_model (
  // Clock and request
  input wire ref_clk_in,
  input wire [2:0] op_in,
  input wire [7:0] arg_in,
  // Commands
  output reg read_out = 1'b0,
  output reg query_out = 1'b0,
  output reg set_out = 1'b0,
  output reg [7:0] params_out = 8'h00,
  output reg save_out = 1'b0,
  output reg standby_out = 1'b0
);
  ////////////////////////////////////////
  always @(posedge ref_clk_in) begin
    read_out <= op_in == 3'h1;
    query_out <= op_in == 3'h2;
    set_out <= op_in == 3'h3;
    save_out <= op_in == 3'h4;
    // Only a standby command clears a trip
    if (op_in == 3'h5 || op_in == 3'h6) begin
      standby_out <= op_in == 3'h5;
    end
    // Released data toggles so stale values are never trusted
    params_out <= (op_in == 3'h3) ? arg_in : ~params_out;
  end
endmodule // host_link_model

// *** test/supply_status_monitor.sv ***
/* Checker for the status pins, status word and port settings.
   Assumes one controller clock and an async active-low reset. */
`timescale 1ns/100ps
module supply_status_monitor (
  // Clock, reset, inputs
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire standby_in,
  input wire cv_mode_in,
  input wire ovp_trip_in,
  input wire link_is_lan_in,
  input wire rx_parity_err_in,
  input wire rx_overrun_err_in,
  input wire rx_framing_err_in,
  input wire rx_timeout_err_in,
  input wire read_status_word_cmd_in,
  input wire query_status_word_cmd_in,
  input wire save_settings_cmd_in,
  // Outputs watched
  input wire standby_n_out,
  input wire const_voltage_flag_n_out,
  input wire ovp_error_n_out,
  input wire [15:0] link_status_word_out,
  input wire status_valid_out,
  input wire [7:0] port_cfg_out,
  input wire [7:0] saved_cfg_out,
  input wire save_strobe_out,
  input wire [7:0] pause_char_out,
  input wire [7:0] resume_char_out
);
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_req; read_status_word_cmd_in || query_status_word_cmd_in; endsequence
  sequence s_lan_req; s_req ##0 link_is_lan_in; endsequence
  property p_stb_pin; standby_n_out == !standby_in; endproperty
  property p_cv_pin; const_voltage_flag_n_out == !cv_mode_in; endproperty
  property p_ovp_set; ovp_trip_in |=> !ovp_error_n_out; endproperty
  property p_ovp_hold; !ovp_error_n_out && !standby_in |=> !ovp_error_n_out; endproperty
  property p_ovp_clr; standby_in && !ovp_trip_in |=> ovp_error_n_out; endproperty
  property p_read; s_req |=> status_valid_out; endproperty
  property p_lan; s_lan_req |=> link_status_word_out[15:3] == 13'h0000; endproperty
  property p_rx; s_req ##0 !link_is_lan_in |=> link_status_word_out[15:12] ==
    $past({rx_parity_err_in, rx_overrun_err_in, rx_framing_err_in, rx_timeout_err_in});
  endproperty
  property p_chars; pause_char_out == 8'h13 && resume_char_out == 8'h11; endproperty
  property p_save; save_settings_cmd_in |=>
    save_strobe_out && saved_cfg_out == $past(port_cfg_out); endproperty
  a_stb_pin: assert property (p_stb_pin) else $error("standby pin wrong");
  a_cv_pin: assert property (p_cv_pin) else $error("cv pin wrong");
  a_ovp_set: assert property (p_ovp_set) else $error("trip not latched");
  a_ovp_hold: assert property (p_ovp_hold) else $error("trip not held");
  a_ovp_clr: assert property (p_ovp_clr) else $error("trip not cleared");
  a_read: assert property (p_read) else $error("no status answer");
  a_lan: assert property (p_lan) else $error("network word high bits");
  a_rx: assert property (p_rx) else $error("receive error bits wrong");
  a_chars: assert property (p_chars) else $error("flow characters wrong");
  a_save: assert property (p_save) else $error("save copy wrong");
endmodule // supply_status_monitor

bind supply_status_reporting supply_status_monitor mon (.ref_clk_in, .reset_n_in, .standby_in,
  .cv_mode_in, .ovp_trip_in, .link_is_lan_in, .rx_parity_err_in, .rx_overrun_err_in,
  .rx_framing_err_in, .rx_timeout_err_in, .read_status_word_cmd_in, .query_status_word_cmd_in,
  .save_settings_cmd_in, .standby_n_out, .const_voltage_flag_n_out, .ovp_error_n_out,
  .link_status_word_out, .status_valid_out, .port_cfg_out, .saved_cfg_out, .save_strobe_out,
  .pause_char_out, .resume_char_out);

// *** test/tb_top.sv ***
/* Self-checking bench for the supply status reporting block.
   Assumes shortened second and fill counts set by parameter. */
`timescale 1ns/100ps
module tb_top;
  reg ref_clk_in, reset_n_in, cv, trip, lan, cmd_valid, card, given, ready, tog, targ, full;
  reg [3:0] rx;
  reg [2:0] err, op;
  reg [7:0] arg, md, lm, vo, cu, pcfg;
  reg [31:0] ivl;
  wire stb, rd, qr, st, sv, stb_n, cv_n, ovp_n, valid, rem, act, lvalid, fill, cfull;
  wire [7:0] prm, cfg, scfg, lbyte;
  wire [15:0] word;
  wire [31:0] lint;
  integer miscompares, checks, cyc, seed, i;
  logic [7:0] got[$];
  host_link_model host_m (.ref_clk_in(ref_clk_in), .op_in(op), .arg_in(arg), .read_out(rd),
    .query_out(qr), .set_out(st), .params_out(prm), .save_out(sv), .standby_out(stb));
  supply_status_reporting #(.FILL_CYCLES(20), .CLK_HZ(10)) uut (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .standby_in(stb), .cv_mode_in(cv), .ovp_trip_in(trip),
    .link_is_lan_in(lan), .rx_parity_err_in(rx[3]), .rx_overrun_err_in(rx[2]),
    .rx_framing_err_in(rx[1]), .rx_timeout_err_in(rx[0]), .cmd_valid_in(cmd_valid),
    .cmd_error_in(err), .read_status_word_cmd_in(rd), .query_status_word_cmd_in(qr),
    .set_port_params_cmd_in(st), .port_params_in(prm), .save_settings_cmd_in(sv),
    .auto_remote_toggle_cmd_in(tog), .auto_remote_arg_in(targ), .card_present_in(card),
    .log_file_found_in(card), .card_full_in(full), .interval_given_in(given),
    .interval_s_in(ivl), .mode_code_in(md), .limit_code_in(lm), .volt_code_in(vo),
    .curr_code_in(cu), .log_ready_in(ready), .standby_n_out(stb_n),
    .const_voltage_flag_n_out(cv_n), .ovp_error_n_out(ovp_n), .link_status_word_out(word),
    .status_valid_out(valid), .port_cfg_out(cfg), .saved_cfg_out(scfg), .save_strobe_out(),
    .pause_char_out(), .resume_char_out(), .remote_out(rem), .log_byte_out(lbyte),
    .log_valid_out(lvalid), .log_active_out(act), .log_interval_out(lint),
    .log_fill_out(fill), .log_card_full_out(cfull));
  ////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Three edges: opcode, command strobe, design takes it
  task host(input [2:0] o, input [7:0] a);
    begin
      @(posedge ref_clk_in); op <= o; arg <= a;
      @(posedge ref_clk_in); op <= 3'h0;
      @(posedge ref_clk_in); #1;
    end
  endtask
  function [15:0] exp_word(input [3:0] e, input [7:0] c, input [2:0] r, input n);
    exp_word = n ? {13'h0000, r} : {e, c[7], 1'b0, c[6:1], 1'b0, r};
  endfunction
  function [7:0] rec(input integer k);
    rec = (k == 7) ? 8'h0A : k[0] ? 8'h09 : k == 0 ? md : k == 2 ? lm : k == 4 ? vo : cu;
  endfunction
  initial begin
    ref_clk_in = 0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    ready <= $random(seed); // Random sink stalls
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  always @(negedge ref_clk_in) if (lvalid && ready) got.push_back(lbyte);
  initial begin
    seed = 32'hEF580699; miscompares = 0; checks = 0; cyc = 0;
    {reset_n_in, cv, trip, lan, cmd_valid, card, given, tog, targ, full, rx, err, op, arg} = 0;
    {md, lm, vo, cu, ivl} = 0;
    repeat (6) @(posedge ref_clk_in);
    reset_n_in <= 1;
    @(posedge ref_clk_in); #1;
    chk(cfg, 8'h10); chk(lint, 60); chk(rem, 0); chk(ovp_n, 1);
    // Auto-remote off: a command must not go remote, nor may the re-enabling toggle
    @(posedge ref_clk_in); tog <= 1; targ <= 0;
    @(posedge ref_clk_in); tog <= 0; cmd_valid <= 1;
    @(posedge ref_clk_in); tog <= 1; targ <= 1;
    @(posedge ref_clk_in); tog <= 0; cmd_valid <= 0;
    @(posedge ref_clk_in); #1;
    chk(rem, 0);
    for (i = 0; i < 24; i = i + 1) begin
      @(posedge ref_clk_in);
      rx <= $random(seed); lan <= $random(seed); cv <= $random(seed); cmd_valid <= 1;
      err <= $unsigned($random(seed)) % 7;
      @(posedge ref_clk_in); cmd_valid <= 0;
      host(3'h3, $random(seed)); pcfg = arg; chk(cfg, pcfg);
      host(3'h1 + {2'b0, i[0]}, 8'h00); chk(valid, 1);
      chk(word, exp_word(rx, pcfg, err, lan));
      chk(word & 16'hFBF7, exp_word(rx, pcfg, err, lan) & 16'hFBF7);
      host(3'h2 - {2'b0, i[0]}, 8'h00); chk(word[2:0], 0);
      host(3'h4, 8'h00); chk(scfg, pcfg);
      host(3'h5 + {2'b0, i[1]}, 8'h00); chk(stb_n, !stb); chk(cv_n, !cv);
    end
    chk(rem, 1);
    host(3'h6, 8'h00);
    @(posedge ref_clk_in); trip <= 1;
    @(posedge ref_clk_in); trip <= 0;
    repeat (3) @(posedge ref_clk_in); #1;
    chk(ovp_n, 0);
    host(3'h5, 8'h00); chk(ovp_n, 1);
    @(posedge ref_clk_in); given <= 1; ivl <= 1; card <= 1;
    md <= $random(seed); lm <= $random(seed); vo <= $random(seed); cu <= $random(seed);
    repeat (30) @(posedge ref_clk_in); #1;
    chk(act, 0); chk(got.size(), 0); chk(lint, 1);
    host(3'h6, 8'h00);
    for (i = 0; i < 100 && lvalid !== 1'b1; i = i + 1) begin
      @(posedge ref_clk_in); #1;
    end
    @(posedge ref_clk_in); #1;
    chk(fill, 1); chk(act, 1);
    for (i = 0; i < 200 && got.size() < 8; i = i + 1) @(posedge ref_clk_in);
    for (i = 0; i < 8; i = i + 1) chk(got[i], rec(i));
    @(posedge ref_clk_in); given <= 0; full <= 1;
    repeat (2) @(posedge ref_clk_in); #1;
    chk(lint, 60); chk(cfull, 1);
    end_of_test;
  end
endmodule // tb_top
